//--- rtl/smcc_pkg.sv
// Purpose: constants for the standby and module clock control block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: register offsets are word aligned
package smcc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [3:0] OFS_PDMC = 4'h0; // power_down_mode_control
  localparam logic [3:0] OFS_MCS2 = 4'h4; // module_clock_stop_2
  localparam logic [3:0] OFS_STAT = 4'h8; // read-only status
  localparam logic [7:0] PDMC_RST = 8'h00;
  localparam logic [7:0] MCS2_RST = 8'h00;
  localparam logic [7:0] PDMC_WMASK = 8'h88;
  localparam logic [7:0] MCS2_WMASK = 8'hE6;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int STANDBY_BIT = 7;
  localparam int REFLECT_BIT = 3;
  localparam int DEBUG_IF_BIT = 7;
  localparam int BREAK_BIT = 6;
  localparam int DMA_BIT = 5;
  localparam int CACHE_BIT = 2;
  localparam int LMEM_BIT = 1;
  localparam int N_GATED = 5;
  // gated unit index -> stop bit position in module_clock_stop_2
  localparam int STOP_POS [N_GATED] = '{DEBUG_IF_BIT, BREAK_BIT, DMA_BIT, CACHE_BIT, LMEM_BIT};
  localparam logic [N_GATED-1:0] CLK_EN_RST = 5'h1F;
  // status layout: [2:0] applied mode, [6:4] filtered pins
  localparam int STAT_PIN_LSB = 4;
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [1:0] INIT_DONE = 2'h3;
endpackage

//--- rtl/smcc_top.sv
// Purpose: power-down mode control and module clock stop registers
// Assumes: single 125 MHz clock, synchronous active-high reset
// Notes: clock stops leave as registered enables for external gating cells
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - bit 7 of power-down control picks sleep (0) or software standby (1).
// - reserved bits read as zero; software writes zero to them.
// - reflect bit 3 set applies mode pins on interrupt return from standby.
// - debug_if_stop bit 7 halts debug interface clock; clear lets it run.
// - break_unit_stop bit 6 halts user break unit clock.
// - dma_stop bit 5 halts DMA controller clock.
// - cache_stop bit 2 halts cache memory clock.
// - local_mem_stop bit 1 halts local U memory clock.
// - both 8-bit registers read/write, all writable bits reset to zero.
module smcc_top (
  input wire logic clk_i,                    // system clock
  input wire logic rst_i,                    // sync reset, active high
  input wire logic cyc_i,                    // wishbone cycle
  input wire logic stb_i,                    // wishbone strobe
  input wire logic we_i,                     // wishbone write
  input wire logic [smcc_pkg::ADR_W-1:0] adr_i, // byte address
  input wire logic [3:0] sel_i,              // byte selects
  input wire logic [31:0] dat_i,             // write data
  output logic [31:0] dat_o,                 // read data
  output logic ack_o,                        // wishbone ack
  input wire logic [2:0] mode_pins_i,        // mode_select_pins, async
  input wire logic standby_wake_irq_i,       // pulse: standby left by interrupt
  output logic standby_select_o,             // sleep instruction goes to standby
  output logic [2:0] mode_o,                 // applied operating mode
  output logic [smcc_pkg::N_GATED-1:0] clk_en_o // debug, break, dma, cache, lmem
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pdmc;
    logic [7:0] mcs2;
    logic ack;
    logic [7:0] rdata;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] pins;
    logic [2:0] mode;
    logic [1:0] init;
    logic [smcc_pkg::N_GATED-1:0] clk_en;
  } smcc_state_s;

  smcc_state_s st_reg;
  smcc_state_s st_next;
  logic req;
  logic [smcc_pkg::N_GATED-1:0] run;
  logic [7:0] status;

  assign req = cyc_i & stb_i & ~st_reg.ack;
  assign status = {1'b0, st_reg.pins, 1'b0, st_reg.mode};

  // ------------------------------------------------------------
  // per-unit run enables
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < smcc_pkg::N_GATED; g++) begin : g_gate
      assign run[g] = ~st_reg.mcs2[smcc_pkg::STOP_POS[g]];
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.ack = req;
    // first stage feeds only the second
    st_next.s1 = mode_pins_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.pins = st_reg.s3;
    end
    // strap the pins on the third cycle after reset, before the filter has filled, so mode takes the reset value of pins
    if (st_reg.init != smcc_pkg::INIT_DONE) begin
      st_next.init = st_reg.init + 2'h1;
      if (st_reg.init == smcc_pkg::INIT_DONE - 2'h1) begin
        st_next.mode = st_reg.pins;
      end
    end else if (standby_wake_irq_i && st_reg.pdmc[smcc_pkg::REFLECT_BIT]) begin
      st_next.mode = st_reg.pins;
    end
    // registered enable so an external latch gate never sees a glitch
    st_next.clk_en = run;
    if (req) begin
      case (adr_i)
        smcc_pkg::OFS_PDMC: st_next.rdata = st_reg.pdmc;
        smcc_pkg::OFS_MCS2: st_next.rdata = st_reg.mcs2;
        smcc_pkg::OFS_STAT: st_next.rdata = status;
        default: st_next.rdata = 8'h00;
      endcase
      if (we_i && sel_i[0]) begin
        case (adr_i)
          smcc_pkg::OFS_PDMC: st_next.pdmc = dat_i[7:0] & smcc_pkg::PDMC_WMASK;
          smcc_pkg::OFS_MCS2: st_next.mcs2 = dat_i[7:0] & smcc_pkg::MCS2_WMASK;
          default: st_next.init = st_next.init;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.pdmc <= smcc_pkg::PDMC_RST;
      st_reg.mcs2 <= smcc_pkg::MCS2_RST;
      st_reg.mode <= smcc_pkg::MODE_RST;
      st_reg.clk_en <= smcc_pkg::CLK_EN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign dat_o = {24'h000000, st_reg.rdata};
  assign ack_o = st_reg.ack;
  assign standby_select_o = st_reg.pdmc[smcc_pkg::STANDBY_BIT];
  assign mode_o = st_reg.mode;
  assign clk_en_o = st_reg.clk_en;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic wr_pdmc;
  logic wr_mcs2;
  assign wr_pdmc = req & we_i & sel_i[0] & (adr_i == smcc_pkg::OFS_PDMC);
  assign wr_mcs2 = req & we_i & sel_i[0] & (adr_i == smcc_pkg::OFS_MCS2);

  chk_standby_select: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_pdmc |=> (standby_select_o == $past(dat_i[7])))
    else $error("standby select does not follow write");

  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(adr_i) == smcc_pkg::OFS_PDMC) |-> (dat_o[6:4] == 3'h0 && dat_o[2:0] == 3'h0))
    else $error("reserved control bits read nonzero");

  chk_reserved_mcs2: assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(adr_i) == smcc_pkg::OFS_MCS2) |-> (dat_o[4:3] == 2'h0 && !dat_o[0]))
    else $error("reserved stop bits read nonzero");

  chk_mode_reflect: assert property (@(posedge clk_i) disable iff (rst_i)
    (standby_wake_irq_i && st_reg.pdmc[smcc_pkg::REFLECT_BIT] && st_reg.init == smcc_pkg::INIT_DONE)
    |=> mode_o == $past(st_reg.pins))
    else $error("mode pins not applied on wake");

  chk_mode_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.init == smcc_pkg::INIT_DONE && !st_reg.pdmc[smcc_pkg::REFLECT_BIT]) |=> $stable(mode_o))
    else $error("mode changed while reflect is off");

  chk_debug_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mcs2 ##1 !wr_mcs2 |=> (clk_en_o[0] == !$past(dat_i[7], 2)))
    else $error("debug interface enable wrong");

  chk_break_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mcs2 ##1 !wr_mcs2 |=> (clk_en_o[1] == !$past(dat_i[6], 2)))
    else $error("break unit enable wrong");

  chk_dma_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mcs2 ##1 !wr_mcs2 |=> (clk_en_o[2] == !$past(dat_i[5], 2)))
    else $error("dma enable wrong");

  chk_cache_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mcs2 ##1 !wr_mcs2 |=> (clk_en_o[3] == !$past(dat_i[2], 2)))
    else $error("cache enable wrong");

  chk_lmem_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_mcs2 ##1 !wr_mcs2 |=> (clk_en_o[4] == !$past(dat_i[1], 2)))
    else $error("local memory enable wrong");

  chk_reset_values: assert property (@(posedge clk_i)
    $past(rst_i) |-> (st_reg.pdmc == 8'h00 && st_reg.mcs2 == 8'h00 && clk_en_o == 5'h1F))
    else $error("reset values wrong");

  chk_gate_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !$changed(st_reg.mcs2) ##1 !$changed(st_reg.mcs2) |-> $stable(clk_en_o))
    else $error("clock enable moved without a stop bit change");

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // ------------------------------------------------------------
  // bus handshake checks
  // ------------------------------------------------------------
  // ack is registered: one fixed cycle of latency, no wait states
  chk_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("request not acknowledged next cycle");

  chk_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_o)
    else $error("ack without a request");

  chk_ack_low_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> !ack_o)
    else $error("ack high after reset");

  chk_dat_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read bits nonzero");

  chk_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> $stable(dat_o))
    else $error("read data moved without a request");

  // ------------------------------------------------------------
  // register checks
  // ------------------------------------------------------------
  chk_read_pdmc: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == smcc_pkg::OFS_PDMC) |=> dat_o[7:0] == $past(st_reg.pdmc))
    else $error("control read data wrong");

  chk_read_mcs2: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == smcc_pkg::OFS_MCS2) |=> dat_o[7:0] == $past(st_reg.mcs2))
    else $error("stop register read data wrong");

  chk_read_stat: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == smcc_pkg::OFS_STAT) |=> dat_o[7:0] == $past(status))
    else $error("status read data wrong");

  chk_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && adr_i != smcc_pkg::OFS_PDMC && adr_i != smcc_pkg::OFS_MCS2
      && adr_i != smcc_pkg::OFS_STAT) |=> dat_o == 32'h00000000)
    else $error("unmapped read nonzero");

  chk_pdmc_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_pdmc |=> $stable(st_reg.pdmc))
    else $error("control register moved without a write");

  // a stopped unit relies on its stop bit staying put until software clears it
  chk_mcs2_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_mcs2 |=> $stable(st_reg.mcs2))
    else $error("stop register moved without a write");

  chk_standby_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_pdmc |=> $stable(standby_select_o))
    else $error("standby select moved without a write");

  chk_pdmc_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.pdmc & ~smcc_pkg::PDMC_WMASK) == 8'h00)
    else $error("reserved control bit stored");

  chk_mcs2_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.mcs2 & ~smcc_pkg::MCS2_WMASK) == 8'h00)
    else $error("reserved stop bit stored");

  chk_reflect_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_pdmc |=> st_reg.pdmc[smcc_pkg::REFLECT_BIT] == $past(dat_i[smcc_pkg::REFLECT_BIT]))
    else $error("reflect bit does not follow write");

  chk_clk_en_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> clk_en_o == smcc_pkg::CLK_EN_RST)
    else $error("clock enables not all on after reset");

  // ------------------------------------------------------------
  // pin filter and mode checks
  // ------------------------------------------------------------
  // pins only move once two late stages agree, so a metastable first stage never leaks
  chk_sync_accept: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.s2 == st_reg.s3) |=> st_reg.pins == $past(st_reg.s3))
    else $error("filtered pins missed an agreed level");

  chk_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.s2 != st_reg.s3) |=> $stable(st_reg.pins))
    else $error("filtered pins moved on disagreement");

  chk_strap_once: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.init == smcc_pkg::INIT_DONE - 2'h1) |=> mode_o == $past(st_reg.pins))
    else $error("mode not strapped after reset");

  chk_init_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.init == smcc_pkg::INIT_DONE) |=> st_reg.init == smcc_pkg::INIT_DONE)
    else $error("strap counter left its end value");

  chk_mode_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> mode_o == smcc_pkg::MODE_RST)
    else $error("mode not cleared by reset");

  // after the strap only a wake pulse may alter the applied mode
  chk_mode_wake_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.init == smcc_pkg::INIT_DONE && !standby_wake_irq_i) |=> $stable(mode_o))
    else $error("mode changed without a wake");

  chk_wake_no_reflect: assert property (@(posedge clk_i) disable iff (rst_i)
    (standby_wake_irq_i && !st_reg.pdmc[smcc_pkg::REFLECT_BIT]
      && st_reg.init == smcc_pkg::INIT_DONE) |=> $stable(mode_o))
    else $error("mode applied with reflect off");

endmodule // smcc_top

`default_nettype wire

//--- verif/smcc_tb.sv
// Purpose: self-checking bench for the standby and module clock control block
// Assumes: classic wishbone single cycles, one idle cycle between requests
// Notes: stop bits are observed through the registered clock enables
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [smcc_pkg::ADR_W-1:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] mode_pins_i = 3'h0;
  logic wake_i = 1'b0;
  logic standby_o;
  logic [2:0] mode_o;
  logic [smcc_pkg::N_GATED-1:0] clk_en_o;
  logic [31:0] rd;
  int err_count = 0;
  int n_checks = 0;
  int pos [5] = '{7, 6, 5, 2, 1};
  always #4 clk_i = ~clk_i;
  smcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .mode_pins_i(mode_pins_i), .standby_wake_irq_i(wake_i), .standby_select_o(standby_o),
    .mode_o(mode_o), .clk_en_o(clk_en_o));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait: a slave that never acks ends the run
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (n >= 16) begin
      err_count++;
      $display("MISMATCH t=%0t ack got=%h exp=%h", $time, 1'b0, 1'b1);
      print_verdict();
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse_wake();
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    settle(1);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h0);
    chk({27'h0, clk_en_o}, 32'h1F);
    chk({31'h0, standby_o}, 32'h0);
    $display("test_reset done");
  endtask
  task automatic test_pdmc();
    wb(1'b1, 4'h0, 8'hFF);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h88);
    chk({31'h0, standby_o}, 32'h1);
    wb(1'b1, 4'h0, 8'h7F);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h08);
    chk({31'h0, standby_o}, 32'h0);
    $display("test_pdmc done");
  endtask
  // each stop bit alone must clear exactly its own enable
  task automatic test_stop();
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 4'h4, 8'h01 << pos[i]);
      wb(1'b0, 4'h4, 8'h00);
      chk(rd, 32'h01 << pos[i]);
      chk({27'h0, clk_en_o}, {27'h0, ~(5'h01 << i)});
    end
    wb(1'b1, 4'h4, 8'hFF);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'hE6);
    chk({27'h0, clk_en_o}, 32'h00);
    wb(1'b1, 4'h4, 8'h00);
    settle(2);
    chk({27'h0, clk_en_o}, 32'h1F);
    $display("test_stop done");
  endtask
  task automatic test_mode();
    chk({29'h0, mode_o}, 32'h0);
    mode_pins_i <= 3'h5;
    wb(1'b1, 4'h0, 8'h08);
    settle(6);
    pulse_wake();
    chk({29'h0, mode_o}, 32'h5);
    wb(1'b1, 4'h0, 8'h00);
    mode_pins_i <= 3'h2;
    settle(6);
    pulse_wake();
    chk({29'h0, mode_o}, 32'h5);
    wb(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h25);
    $display("test_mode done");
  endtask
  task automatic test_unmapped();
    wb(1'b1, 4'hC, 8'hFF);
    wb(1'b0, 4'hC, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, 4'h8, 8'hFF);
    wb(1'b0, 4'h8, 8'h00);
    chk(rd, 32'h25);
    $display("test_unmapped done");
  endtask
  // a reset in mid-run must bring both registers back to zero
  task automatic test_mid_reset();
    wb(1'b1, 4'h0, 8'h88);
    wb(1'b1, 4'h4, 8'hE6);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(6);
    wb(1'b0, 4'h0, 8'h00);
    chk(rd, 32'h0);
    chk({31'h0, standby_o}, 32'h0);
    wb(1'b0, 4'h4, 8'h00);
    chk(rd, 32'h0);
    chk({27'h0, clk_en_o}, 32'h1F);
    $display("test_mid_reset done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(6);
    test_reset();
    test_pdmc();
    test_stop();
    test_mode();
    test_unmapped();
    test_mid_reset();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
